/* frp_device.sv */
// Flash read-parameter register pair with serial set-parameter decode.
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
// Overview of operation
// - Persistent and working copies; working one governs
// - Power-up copies persistent into working
// - Pin select bit picks pause or reset
// - Quad enable or quad mode: data line
// - Dedicated reset pin, unless disabled, forces pause role
// - Dummy field 1..15 gives that count
// - Dummy zero uses per-command defaults
// - Burst code maps 8/16/32/64 bytes
// - Wrap bit chooses wrap or whole array
// - 65h writes persistent, C0h/63h writes working
// - All bits reset to zero
// - Host provides enough dummy cycles
// - Host avoids mode and dummy contention
// - Dual double-rate read only in SPI
// - ID and info-row reads follow fast read
// - Quad enable turns pins into data lines
module frp_device (
   // System
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       power_up,
   // Link
   frp_link_if.dev         link,
   // Mode inputs
   input  wire logic       quad_lines_enable,
   input  wire logic       quad_command_mode,
   input  wire logic       has_dedicated_reset,
   input  wire logic       dedicated_reset_disable,
   input  wire logic [7:0] read_opcode,
   // Settings out
   output logic [7:0]      persist_q,
   output logic [7:0]      working_q,
   output logic            pin_is_reset,
   output logic            pin_is_pause,
   output logic            pin_is_data_line_3,
   output logic            wp_is_data_line_2,
   output logic [3:0]      read_dummy,
   output logic [6:0]      burst_bytes,
   output logic            wrap_active,
   output logic            opcode_legal
);
   // -----------------------------------------------------------------
   // Link synchronisers and edge detect
   // -----------------------------------------------------------------
   logic [1:0] sck_s_q, cs_s_q, mosi_s_q;
   logic       sck_d1_q;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sck_s_q  <= 2'h0;
         cs_s_q   <= 2'h3;
         mosi_s_q <= 2'h0;
         sck_d1_q <= 1'b0;
      end else begin
         sck_s_q  <= {sck_s_q[0], link.sck};
         cs_s_q   <= {cs_s_q[0], link.cs_b};
         mosi_s_q <= {mosi_s_q[0], link.mosi};
         sck_d1_q <= sck_s_q[1];
      end
   end
   logic sck_rise;
   assign sck_rise = sck_s_q[1] & ~sck_d1_q;
   // -----------------------------------------------------------------
   // Frame shifter: opcode byte then parameter byte
   // -----------------------------------------------------------------
   logic [15:0] shift_q;
   logic [4:0]  cnt_q;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         shift_q <= 16'h0000;
         cnt_q   <= 5'h00;
      end else if (cs_s_q[1]) begin
         cnt_q <= 5'h00;
      end else if (sck_rise && cnt_q != 5'(frp_pkg::FRAME_BITS)) begin
         shift_q <= {shift_q[14:0], mosi_s_q[1]};
         cnt_q   <= cnt_q + 5'h01;
      end
   end
   logic frame_done;
   assign frame_done = sck_rise && cnt_q == 5'(frp_pkg::FRAME_BITS - 1);
   logic [7:0] op_w;
   assign op_w = shift_q[14:7];
   logic [7:0] data_w;
   assign data_w = {shift_q[6:0], mosi_s_q[1]};
   // -----------------------------------------------------------------
   // Register pair
   // -----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         persist_q <= frp_pkg::PARAM_RESET;
      end else if (frame_done && op_w == frp_pkg::OP_SET_PERSIST) begin
         persist_q <= data_w;
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         working_q <= frp_pkg::PARAM_RESET;
      end else if (power_up) begin
         working_q <= persist_q;
      end else if (frame_done && (op_w == frp_pkg::OP_SET_WORK_A || op_w == frp_pkg::OP_SET_WORK_B)) begin
         working_q <= data_w;
      end
   end
   // -----------------------------------------------------------------
   // Pin role decode from working copy
   // -----------------------------------------------------------------
   logic quad_pins;
   assign quad_pins = quad_lines_enable | quad_command_mode;
   assign pin_is_data_line_3 = quad_pins;
   assign wp_is_data_line_2  = quad_lines_enable;
   assign pin_is_reset = !quad_pins && working_q[frp_pkg::PIN_SEL_BIT]
                         && !(has_dedicated_reset && !dedicated_reset_disable);
   assign pin_is_pause = !quad_pins && !pin_is_reset;
   // -----------------------------------------------------------------
   // Dummy count and burst decode
   // -----------------------------------------------------------------
   function automatic logic [3:0] frp_default_dummy(input logic [7:0] op, input logic qmode);
      case (op)
         frp_pkg::OP_FAST, frp_pkg::OP_FAST_DTR,
         frp_pkg::OP_UNIQUE_ID, frp_pkg::OP_INFO_ROW:
            frp_default_dummy = qmode ? frp_pkg::DUMMY_FAST_QUAD : frp_pkg::DUMMY_FAST_SPI;
         frp_pkg::OP_DUAL_OUT:                  frp_default_dummy = frp_pkg::DUMMY_DUAL_OUT;
         frp_pkg::OP_DUAL_IO, frp_pkg::OP_DUAL_IO_DTR: frp_default_dummy = frp_pkg::DUMMY_DUAL_IO;
         frp_pkg::OP_QUAD_OUT:                  frp_default_dummy = frp_pkg::DUMMY_QUAD_OUT;
         frp_pkg::OP_QUAD_IO, frp_pkg::OP_QUAD_IO_DTR: frp_default_dummy = frp_pkg::DUMMY_QUAD_IO;
         default:                               frp_default_dummy = frp_pkg::DUMMY_FAST_SPI;
      endcase
   endfunction
   logic [3:0] dummy_field;
   assign dummy_field = working_q[frp_pkg::DUMMY_HI:frp_pkg::DUMMY_LO];
   assign read_dummy  = (dummy_field != 4'h0) ? dummy_field
                        : frp_default_dummy(read_opcode, quad_command_mode);
   assign burst_bytes = 7'h08 << working_q[frp_pkg::BURST_HI:frp_pkg::BURST_LO];
   assign wrap_active = working_q[frp_pkg::WRAP_EN_BIT];
   assign opcode_legal = !(quad_command_mode && read_opcode == frp_pkg::OP_DUAL_IO_DTR);
endmodule // frp_device

/* frp_host.sv */
// Host controller: APB registers drive set-parameter frames on the link.
`timescale 1ns/1ns
module frp_host (
   // System
   input  wire logic        clk,
   input  wire logic        rst_b,
   // APB
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Link
   frp_link_if.host         link
);
   // -----------------------------------------------------------------
   // APB slave
   // -----------------------------------------------------------------
   logic [9:0]  ctrl_q;
   logic        busy_q;
   logic [31:0] prdata_q;
   logic        wr_ctrl;
   assign wr_ctrl = psel && penable && pwrite && paddr == frp_pkg::REG_CTRL;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && paddr != frp_pkg::REG_CTRL && paddr != frp_pkg::REG_STATUS;
   assign prdata  = prdata_q;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_q <= 10'h000;
      end else if (wr_ctrl && !busy_q) begin
         ctrl_q <= pwdata[9:0];
      end else begin
         ctrl_q[frp_pkg::CTRL_GO_BIT] <= 1'b0;
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         prdata_q <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata_q <= (paddr == frp_pkg::REG_CTRL)   ? {22'h00_0000, ctrl_q} :
                     (paddr == frp_pkg::REG_STATUS) ? {31'h0000_0000, busy_q} : 32'h0000_0000;
      end
   end
   // -----------------------------------------------------------------
   // Frame sender: opcode 65h or C0h then the parameter byte
   // -----------------------------------------------------------------
   logic [15:0] frame_q;
   logic [4:0]  bits_q;
   logic [2:0]  div_q;
   logic        sck_q;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         busy_q  <= 1'b0;
         frame_q <= 16'h0000;
         bits_q  <= 5'h00;
         div_q   <= 3'h0;
         sck_q   <= 1'b0;
      end else if (!busy_q) begin
         sck_q <= 1'b0;
         if (ctrl_q[frp_pkg::CTRL_GO_BIT]) begin
            busy_q  <= 1'b1;
            bits_q  <= 5'h00;
            div_q   <= 3'h0;
            frame_q <= {ctrl_q[frp_pkg::CTRL_WORK_BIT] ? frp_pkg::OP_SET_WORK_A
                                                       : frp_pkg::OP_SET_PERSIST, ctrl_q[7:0]};
         end
      end else if (div_q == 3'(frp_pkg::CLK_DIV - 1)) begin
         div_q <= 3'h0;
         sck_q <= ~sck_q;
         if (sck_q) begin
            frame_q <= {frame_q[14:0], 1'b0};
            bits_q  <= bits_q + 5'h01;
            if (bits_q == 5'(frp_pkg::FRAME_BITS - 1)) begin
               busy_q <= 1'b0;
            end
         end
      end else begin
         div_q <= div_q + 3'h1;
      end
   end
   assign link.sck  = sck_q;
   assign link.cs_b = ~busy_q;
   assign link.mosi = frame_q[15];
endmodule // frp_host

/* frp_link_if.sv */
// Interface joining the host controller and the flash read-parameter block.
`timescale 1ns/1ns
interface frp_link_if;
   logic sck;
   logic cs_b;
   logic mosi;
   modport host (output sck, output cs_b, output mosi);
   modport dev  (input sck, input cs_b, input mosi);
endinterface : frp_link_if

/* frp_link_properties.sv */
// Checker watching the link wires and the read-parameter decode.
`timescale 1ns/1ns
module frp_link_properties (
   // Clock and reset
   input wire logic       clk,
   input wire logic       rst_b,
   // Link
   input wire logic       sck,
   input wire logic       cs_b,
   // Device side
   input wire logic       power_up,
   input wire logic       quad_lines_enable,
   input wire logic [7:0] persist_q,
   input wire logic [7:0] working_q,
   input wire logic [3:0] read_dummy,
   input wire logic [6:0] burst_bytes,
   input wire logic       wrap_active,
   input wire logic       pin_is_reset,
   input wire logic       pin_is_data_line_3
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_sck_idle_low:
      assert property (cs_b |-> !sck) else $error("sck high while deselected");
   a_sck_half_period:
      assert property ($rose(sck) |-> sck[*4] ##1 !sck) else $error("sck high phase not four cycles");
   a_power_load:
      assert property (power_up |=> working_q == $past(persist_q)) else $error("power-up load missed");
   a_persist_apart:
      assert property ($changed(persist_q) |-> $stable(working_q)) else $error("working copy moved");
   a_dummy_count:
      assert property (working_q[6:3] != 4'h0 |-> read_dummy == working_q[6:3]) else $error("dummy count wrong");
   a_burst_map:
      assert property (burst_bytes == (7'h08 << working_q[1:0])) else $error("burst size wrong");
   a_wrap_follow:
      assert property (wrap_active == working_q[2]) else $error("wrap flag wrong");
   a_quad_data_line:
      assert property (quad_lines_enable |-> pin_is_data_line_3 && !pin_is_reset) else $error("pin not data line");
   a_pin_reset_sel:
      assert property (pin_is_reset |-> working_q[7] && !quad_lines_enable) else $error("reset role unselected");
endmodule // frp_link_properties

/* frp_pkg.sv */
// Package holding constants shared by both ends of the read-parameter link.
package frp_pkg;
   // -----------------------------------------------------------------
   // Instruction codes
   // -----------------------------------------------------------------
   localparam logic [7:0] OP_SET_PERSIST  = 8'h65;
   localparam logic [7:0] OP_SET_WORK_A   = 8'hC0;
   localparam logic [7:0] OP_SET_WORK_B   = 8'h63;
   localparam logic [7:0] OP_FAST         = 8'h0B;
   localparam logic [7:0] OP_FAST_DTR     = 8'h0D;
   localparam logic [7:0] OP_DUAL_OUT     = 8'h3B;
   localparam logic [7:0] OP_DUAL_IO      = 8'hBB;
   localparam logic [7:0] OP_DUAL_IO_DTR  = 8'hBD;
   localparam logic [7:0] OP_QUAD_OUT     = 8'h6B;
   localparam logic [7:0] OP_QUAD_IO      = 8'hEB;
   localparam logic [7:0] OP_QUAD_IO_DTR  = 8'hED;
   localparam logic [7:0] OP_UNIQUE_ID    = 8'h4B;
   localparam logic [7:0] OP_INFO_ROW     = 8'h68;
   // -----------------------------------------------------------------
   // Read-parameter field layout and reset value
   // -----------------------------------------------------------------
   localparam int         PIN_SEL_BIT     = 7;
   localparam int         DUMMY_HI        = 6;
   localparam int         DUMMY_LO        = 3;
   localparam int         WRAP_EN_BIT     = 2;
   localparam int         BURST_HI        = 1;
   localparam int         BURST_LO        = 0;
   localparam logic [7:0] PARAM_RESET     = 8'h00;
   // -----------------------------------------------------------------
   // Default dummy counts when the field is zero
   // -----------------------------------------------------------------
   localparam logic [3:0] DUMMY_FAST_SPI  = 4'h8;
   localparam logic [3:0] DUMMY_FAST_QUAD = 4'h6;
   localparam logic [3:0] DUMMY_DUAL_OUT  = 4'h8;
   localparam logic [3:0] DUMMY_DUAL_IO   = 4'h4;
   localparam logic [3:0] DUMMY_QUAD_OUT  = 4'h8;
   localparam logic [3:0] DUMMY_QUAD_IO   = 4'h6;
   // -----------------------------------------------------------------
   // Host register map over APB
   // -----------------------------------------------------------------
   localparam logic [7:0] REG_CTRL        = 8'h00;
   localparam logic [7:0] REG_STATUS      = 8'h04;
   localparam int         CTRL_GO_BIT     = 8;
   localparam int         CTRL_WORK_BIT   = 9;
   localparam int         CLK_DIV         = 4;
   localparam int         FRAME_BITS      = 16;
endpackage : frp_pkg

/* test_flash_read_parameter_register.sv */
// Self-checking bench driving the host over APB and watching the device.
`timescale 1ns/1ns
module test_flash_read_parameter_register;
   logic        clk = 0, rst_b = 0, power_up = 0, psel = 0, penable = 0, pwrite = 0, err;
   logic        quad_en = 0, quad_cmd = 0, ded_pin = 0, ded_off = 0, pready, pslverr;
   logic        pin_is_reset, pin_is_pause, pin_dl3, wp_dl2, wrap_active, opcode_legal;
   logic [7:0]  paddr = 0, opcode = 8'h0B, persist_q, working_q;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [3:0]  read_dummy;
   logic [6:0]  burst_bytes;
   logic [7:0]  ops [10] = '{8'h0B, 8'h0D, 8'h3B, 8'hBB, 8'hBD, 8'h6B, 8'hEB, 8'hED, 8'h4B, 8'h68};
   logic [3:0]  dfl [10] = '{4'h8, 4'h8, 4'h8, 4'h4, 4'h4, 4'h8, 4'h6, 4'h6, 4'h8, 4'h8};
   int          failures = 0, n_tests = 0;
   frp_link_if link ();
   always #4 clk = ~clk;
   frp_host u_frp_host (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
   frp_device u_frp_device (.clk(clk), .rst_b(rst_b), .power_up(power_up), .link(link),
      .quad_lines_enable(quad_en), .quad_command_mode(quad_cmd), .has_dedicated_reset(ded_pin),
      .dedicated_reset_disable(ded_off), .read_opcode(opcode), .persist_q(persist_q), .working_q(working_q),
      .pin_is_reset(pin_is_reset), .pin_is_pause(pin_is_pause), .pin_is_data_line_3(pin_dl3),
      .wp_is_data_line_2(wp_dl2), .read_dummy(read_dummy), .burst_bytes(burst_bytes),
      .wrap_active(wrap_active), .opcode_legal(opcode_legal));
   frp_link_properties u_frp_link_properties (.clk(clk), .rst_b(rst_b), .sck(link.sck), .cs_b(link.cs_b),
      .power_up(power_up), .quad_lines_enable(quad_en), .persist_q(persist_q), .working_q(working_q),
      .read_dummy(read_dummy), .burst_bytes(burst_bytes), .wrap_active(wrap_active),
      .pin_is_reset(pin_is_reset), .pin_is_data_line_3(pin_dl3));
   // -----------------------------------------------------------------
   // Bus and compare tasks
   // -----------------------------------------------------------------
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Starts a frame and polls busy until the link falls quiet.
   task automatic send(input logic work, input logic [7:0] v);
      apb(1'b1, frp_pkg::REG_CTRL, {22'h0, work, 1'b1, v});
      rd = 32'h1;
      while (rd[0] !== 1'b0) apb(1'b0, frp_pkg::REG_STATUS, 32'h0);
      repeat (8) @(posedge clk);
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      if (failures == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // -----------------------------------------------------------------
   // Tests
   // -----------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      chk(persist_q, 8'h00);
      chk(working_q, 8'h00);
      chk(pin_is_pause, 1'b1);
      send(1'b0, 8'h9D);
      chk(persist_q, 8'h9D);
      chk(working_q, 8'h00);
      power_up <= 1'b1;
      @(posedge clk);
      power_up <= 1'b0;
      repeat (2) @(posedge clk);
      chk(working_q, 8'h9D);
      chk(pin_is_reset, 1'b1);
      chk(read_dummy, 4'h3);
      chk(burst_bytes, 7'h10);
      chk(wrap_active, 1'b1);
      send(1'b1, 8'h02);
      chk(working_q, 8'h02);
      chk(persist_q, 8'h9D);
      chk(burst_bytes, 7'h20);
      chk(wrap_active, 1'b0);
      foreach (ops[i]) begin
         opcode <= ops[i];
         repeat (2) @(posedge clk);
         chk(read_dummy, dfl[i]);
      end
      quad_en <= 1'b1;
      repeat (2) @(posedge clk);
      chk(pin_dl3, 1'b1);
      chk(wp_dl2, 1'b1);
      quad_en <= 1'b0;
      quad_cmd <= 1'b1;
      opcode <= 8'hBD;
      repeat (2) @(posedge clk);
      chk(opcode_legal, 1'b0);
      chk(pin_dl3, 1'b1);
      opcode <= 8'h0B;
      repeat (2) @(posedge clk);
      chk(read_dummy, 4'h6);
      quad_cmd <= 1'b0;
      opcode <= 8'hBD;
      repeat (2) @(posedge clk);
      chk(opcode_legal, 1'b1);
      send(1'b1, 8'hF8);
      chk(read_dummy, 4'hF);
      chk(burst_bytes, 7'h08);
      ded_pin <= 1'b1;
      repeat (2) @(posedge clk);
      chk(pin_is_pause, 1'b1);
      ded_off <= 1'b1;
      repeat (2) @(posedge clk);
      chk(pin_is_reset, 1'b1);
      apb(1'b0, 8'h20, 32'h0);
      chk(err, 1'b1);
      chk(rd, 32'h0);
      close_out();
   end
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      close_out();
   end
endmodule // test_flash_read_parameter_register
